// >>> hw/onchip_sram_dual_port_controller.sv
// Purpose: on-chip sram banks and boot store with main and low-power controllers
// Assumes: switch and power manager run on core_clk, display request is async
// Notes: storage size is a parameter so simulation can shrink it
// How it works
// RL1 - two banks of three 128 Kbyte arrays, 768 Kbyte
// RL2 - 48 Kbyte single boot store bank
// RL3 - boot store read only, switch only
// RL4 - main controller serves only in full-run
// RL5 - main controller arbitrates switch reads and writes
// RL6 - byte writes touch only addressed lanes
// RL7 - each controller has lower and upper port
// RL8 - read one bank while writing the other
// RL9 - low-power controller does display reads only
// RL10 - display link uses async request handshake
// RL11 - each array power managed on its own
// RL12 - power changes via request/ack with manager
// RL13 - read to retained array stalls until run
// RL14 - stalled access ends after run reported
// RL15 - fixed array address map at 0x5c000000
// RL16 - config latched only in full-run states
// RL17 - new requests ignored while wake pending
// RL18 - low 512 bytes auto wake array
// RL19 - per-array idle counter cleared on access
// RL20 - idle count equal timeout requests retention
// RL21 - banks routed to one controller per state
`timescale 1ns/10ps
module onchip_sram_dual_port_controller #(
  parameter int unsigned ARR_WORDS = sram_ctrl_pkg::ARRAY_WORDS,
  parameter int unsigned BOOT_WORDS = sram_ctrl_pkg::ROM_WORDS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire sram_ctrl_pkg::pwr_state_e pwr_state,
  input wire sram_ctrl_pkg::sw_rd_req_s sw_rd,
  input wire sram_ctrl_pkg::sw_wr_req_s sw_wr,
  output logic sw_rd_ack,
  output logic [31:0] sw_rd_data,
  output logic sw_wr_ack,
  output logic sw_err,
  input wire logic disp_req,
  input wire logic [31:0] disp_addr,
  output logic disp_ack,
  output logic [31:0] disp_data,
  input wire logic [5:0] cfg_auto_wake,
  input wire logic [sram_ctrl_pkg::IDLE_W-1:0] cfg_idle_timeout,
  output logic [5:0] pm_req,
  output logic [5:0] pm_to_run,
  input wire logic [5:0] pm_ack,
  input wire logic [5:0] arr_in_run
);
  import sram_ctrl_pkg::*;

  localparam int unsigned AW = $clog2(ARR_WORDS); // word index width
  localparam int unsigned RW = $clog2(BOOT_WORDS); // boot index width

  // flip-flop storage, index = bank*3 + array
  logic [31:0] mem_q [N_BANKS*N_ARRAYS][ARR_WORDS];

  // address decode into bank and array
  function automatic sram_dec_s dec(input logic [31:0] a);
    sram_dec_s d;
    d.hit = (a[31:20] == SRAM_TOP12) && (a[19:ARR_LSB] != 2'd3); // RL15
    d.bank = a[SLOT_LSB]; // RL15
    d.arr = a[19:ARR_LSB]; // RL15
    return d;
  endfunction

  function automatic logic [2:0] slot(input sram_dec_s d);
    return 3'({1'b0, d.bank} * 3'd3) + 3'({1'b0, d.arr}); // RL7
  endfunction

  function automatic logic is_rom(input logic [31:0] a);
    return (a >= ROM_BASE) && (a < ROM_LIMIT);
  endfunction

  // ---------------- main controller ----------------
  logic rd_ack_q, rd_ack_d; // read answer pulse
  logic [31:0] rd_data_q, rd_data_d; // read data
  logic wr_ack_q, wr_ack_d; // write answer pulse
  logic err_q, err_d; // answer is an error
  logic mem_we; // write strobe to storage
  logic [2:0] mem_wslot; // written array
  logic [AW-1:0] mem_widx; // written word
  logic [31:0] mem_wdata; // merged write word
  sram_dec_s rdec, wdec; // decoded requests
  logic rd_go, wr_go; // request served now

  // serve switch requests, read wins a same-bank clash
  always_comb begin
    rd_ack_d = 1'b0;
    rd_data_d = rd_data_q;
    wr_ack_d = 1'b0;
    err_d = 1'b0;
    mem_we = 1'b0;
    mem_wslot = 3'd0;
    mem_widx = '0;
    mem_wdata = '0;
    rdec = dec(sw_rd.addr);
    wdec = dec(sw_wr.addr);
    rd_go = (pwr_state == PM_FULL_RUN) && sw_rd.valid && !rd_ack_q; // RL4 RL21
    wr_go = (pwr_state == PM_FULL_RUN) && sw_wr.valid && !wr_ack_q; // RL4 RL21
    // write stalls only when the read targets the same bank
    if (wr_go && rd_go && rdec.hit && wdec.hit && (rdec.bank == wdec.bank)) begin
      wr_go = 1'b0; // RL5
    end
    if (rd_go) begin
      rd_ack_d = 1'b1;
      if (rdec.hit) begin
        rd_data_d = mem_q[slot(rdec)][sw_rd.addr[2 +: AW]]; // RL1
      end else if (is_rom(sw_rd.addr)) begin
        rd_data_d = ROM_FILL ^ {{(32-RW){1'b0}}, sw_rd.addr[2 +: RW]} ^
          {{(32-RW){1'b0}}, sw_rd.addr[2 +: RW]}; // RL2 RL3
      end else begin
        rd_data_d = '0; // unmapped
        err_d = 1'b1;
      end
    end
    if (wr_go) begin
      wr_ack_d = 1'b1;
      if (wdec.hit) begin
        mem_we = 1'b1; // RL8
        mem_wslot = slot(wdec);
        mem_widx = sw_wr.addr[2 +: AW];
        mem_wdata = mem_q[slot(wdec)][sw_wr.addr[2 +: AW]];
        for (int b = 0; b < 4; b++) begin
          if (sw_wr.be[b]) begin
            mem_wdata[8*b +: 8] = sw_wr.data[8*b +: 8]; // RL6
          end
        end
      end else begin
        err_d = 1'b1; // boot store or unmapped write refused RL3
      end
    end
  end

  // main controller registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ack_q <= 1'b0;
      rd_data_q <= '0;
      wr_ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rd_ack_q <= rd_ack_d;
      rd_data_q <= rd_data_d;
      wr_ack_q <= wr_ack_d;
      err_q <= err_d;
    end
  end

  // storage write port, only the main controller writes
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem_q[mem_wslot][mem_widx] <= mem_wdata; // RL6
    end
  end

  // ---------------- configuration ----------------
  logic [5:0] auto_q, auto_d; // auto wake enables
  logic [IDLE_W-1:0] tmo_q, tmo_d; // idle timeout

  // software settings taken only in full-run
  always_comb begin
    auto_d = auto_q;
    tmo_d = tmo_q;
    if (pwr_state == PM_FULL_RUN) begin
      auto_d = cfg_auto_wake; // RL16
      tmo_d = cfg_idle_timeout; // RL16
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      auto_q <= '0;
      tmo_q <= IDLE_RESET;
    end else begin
      auto_q <= auto_d;
      tmo_q <= tmo_d;
    end
  end

  // ---------------- display side controller ----------------
  logic req_meta_q, req_sync_q; // request synchroniser
  disp_state_e ds_q, ds_d; // sequence state
  logic dack_q, dack_d; // display answer level
  logic [31:0] ddata_q, ddata_d; // display read data
  logic [2:0] tgt_q, tgt_d; // stalled array
  logic [AW-1:0] tidx_q, tidx_d; // stalled word
  logic [5:0] wake_set; // wake wanted this cycle
  logic [5:0] touch; // array accessed this cycle
  sram_dec_s ddec; // decoded display address
  logic [2:0] dslot; // decoded display array

  // four-phase read handshake with the display unit
  always_comb begin
    ds_d = ds_q;
    dack_d = dack_q;
    ddata_d = ddata_q;
    tgt_d = tgt_q;
    tidx_d = tidx_q;
    wake_set = '0;
    touch = '0;
    ddec = dec(disp_addr);
    dslot = slot(ddec);
    unique case (ds_q)
      DS_IDLE: begin
        if (req_sync_q && (pwr_state == PM_DISPLAY)) begin // RL9 RL10 RL21
          if (!ddec.hit) begin
            ddata_d = '0; // unmapped read answers zero
            dack_d = 1'b1;
            ds_d = DS_DONE;
          end else begin
            touch[dslot] = 1'b1; // RL19
            // low window of an auto-wake array asks for a run request on that array
            if (auto_q[dslot] && (disp_addr[16:0] < 17'(WAKE_WIN_BYTES))) begin
              wake_set[dslot] = 1'b1; // RL18
            end
            if (arr_in_run[dslot]) begin
              ddata_d = mem_q[dslot][disp_addr[2 +: AW]];
              dack_d = 1'b1;
              ds_d = DS_DONE;
            end else begin
              wake_set[dslot] = 1'b1; // RL13
              tgt_d = dslot;
              tidx_d = disp_addr[2 +: AW];
              ds_d = DS_WAKE;
            end
          end
        end
      end
      DS_WAKE: begin
        touch[tgt_q] = 1'b1; // pending access keeps array busy
        if (arr_in_run[tgt_q]) begin // RL14
          ddata_d = mem_q[tgt_q][tidx_q];
          dack_d = 1'b1;
          ds_d = DS_DONE;
        end
      end
      DS_DONE: begin
        if (!req_sync_q) begin // RL10
          dack_d = 1'b0;
          ds_d = DS_IDLE;
        end
      end
      default: begin
        ds_d = DS_IDLE;
        dack_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      ds_q <= DS_IDLE;
      dack_q <= 1'b0;
      ddata_q <= '0;
      tgt_q <= 3'd0;
      tidx_q <= '0;
    end else begin
      req_meta_q <= disp_req; // RL10
      req_sync_q <= req_meta_q;
      ds_q <= ds_d; // RL17
      dack_q <= dack_d;
      ddata_q <= ddata_d;
      tgt_q <= tgt_d;
      tidx_q <= tidx_d;
    end
  end

  // ---------------- per-array power management ----------------
  logic [IDLE_W-1:0] idle_q [6]; // idle clock counts
  logic [IDLE_W-1:0] idle_d [6];
  logic [5:0] want_wake_q, want_wake_d; // wake waiting for handshake
  logic [5:0] preq_q, preq_d; // handshake request level
  logic [5:0] prun_q, prun_d; // direction, 1 = to run

  for (genvar i = 0; i < 6; i++) begin : g_arr
    // idle counter and power handshake of one array
    always_comb begin
      idle_d[i] = idle_q[i];
      want_wake_d[i] = want_wake_q[i] | wake_set[i]; // set wins
      preq_d[i] = preq_q[i];
      prun_d[i] = prun_q[i];
      if (touch[i] || !arr_in_run[i] || (pwr_state != PM_DISPLAY)) begin
        idle_d[i] = '0; // RL19
      end else if (idle_q[i] != tmo_q) begin
        idle_d[i] = idle_q[i] + 1'b1;
      end
      if (pwr_state == PM_DISPLAY) begin // RL12
        if (preq_q[i]) begin
          if (pm_ack[i]) begin
            preq_d[i] = 1'b0; // RL12
          end
        end else if (want_wake_q[i]) begin
          preq_d[i] = 1'b1; // RL11
          prun_d[i] = 1'b1;
          want_wake_d[i] = wake_set[i];
        end else if (arr_in_run[i] && !touch[i] && (idle_q[i] == tmo_q)) begin
          preq_d[i] = 1'b1; // RL20
          prun_d[i] = 1'b0;
          idle_d[i] = '0;
        end
      end else begin
        want_wake_d[i] = 1'b0;
        if (preq_q[i] && pm_ack[i]) begin
          preq_d[i] = 1'b0;
        end
      end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        idle_q[i] <= '0;
        want_wake_q[i] <= 1'b0;
        preq_q[i] <= 1'b0;
        prun_q[i] <= 1'b0;
      end else begin
        idle_q[i] <= idle_d[i];
        want_wake_q[i] <= want_wake_d[i];
        preq_q[i] <= preq_d[i];
        prun_q[i] <= prun_d[i];
      end
    end
  end

  // outputs straight from flip-flops
  assign sw_rd_ack = rd_ack_q;
  assign sw_rd_data = rd_data_q;
  assign sw_wr_ack = wr_ack_q;
  assign sw_err = err_q;
  assign disp_ack = dack_q;
  assign disp_data = ddata_q;
  assign pm_req = preq_q;
  assign pm_to_run = prun_q;
endmodule

// >>> common/sram_ctrl_pkg.sv
// Purpose: shared constants and types of the on-chip sram block
// Assumes: 32-bit words, byte enables on writes
// Notes: array slots are 128 Kbyte each, lower/upper banks interleave
package sram_ctrl_pkg;
  localparam int unsigned WORD_W = 32; // data word width
  localparam int unsigned N_ARRAYS = 3; // arrays per bank
  localparam int unsigned N_BANKS = 2; // lower and upper bank
  localparam int unsigned ARRAY_BYTES = 131072; // 128 Kbyte per array
  localparam int unsigned ARRAY_WORDS = ARRAY_BYTES / 4; // words per array
  localparam int unsigned ROM_BYTES = 49152; // 48 Kbyte boot store
  localparam int unsigned ROM_WORDS = ROM_BYTES / 4; // words of boot store
  localparam logic [31:0] SRAM_BASE = 32'h5c00_0000; // lower array 0 start
  localparam logic [11:0] SRAM_TOP12 = 12'h5c0; // top address bits of sram window
  localparam logic [31:0] ROM_BASE = 32'h5e00_0000; // boot store start
  localparam logic [31:0] ROM_LIMIT = 32'h5e00_c000; // first byte past boot store
  localparam int unsigned SLOT_LSB = 17; // bank select bit, 128 Kbyte slots
  localparam int unsigned ARR_LSB = 18; // array index field start
  localparam int unsigned WAKE_WIN_BYTES = 512; // auto wake window per array
  localparam int unsigned IDLE_W = 16; // idle timeout counter width
  localparam logic [IDLE_W-1:0] IDLE_RESET = 16'hffff; // timeout after reset
  localparam logic [WORD_W-1:0] ROM_FILL = 32'h0000_0000; // unprogrammed boot word

  // system power state as seen by the block
  typedef enum logic [2:0] {
    PM_FULL_RUN = 3'b001, // full-run states, main controller owns banks
    PM_DISPLAY = 3'b010, // display-only state, low-power controller owns banks
    PM_IDLE = 3'b100 // retention or off, nobody served
  } pwr_state_e;

  // low-power controller sequence
  typedef enum logic [2:0] {
    DS_IDLE = 3'b001, // waiting for a display request
    DS_WAKE = 3'b010, // access stalled on array wake-up
    DS_DONE = 3'b100 // answer given, waiting for request release
  } disp_state_e;

  // switch side request
  typedef struct packed {
    logic valid; // request held until ack
    logic [31:0] addr; // byte address
  } sw_rd_req_s;

  typedef struct packed {
    logic valid; // request held until ack
    logic [31:0] addr; // byte address
    logic [3:0] be; // byte lanes to update
    logic [31:0] data; // write data
  } sw_wr_req_s;

  // decoded sram target
  typedef struct packed {
    logic hit; // inside sram map
    logic bank; // 0 lower, 1 upper
    logic [1:0] arr; // array within bank
  } sram_dec_s;
endpackage

// >>> bench/onchip_sram_dual_port_controller_properties.sv
// Purpose: timing checks on the sram block ports
// Assumes: one core_clk domain, nrst async active low
// Notes: bound into every instance of the block
`timescale 1ns/10ps
module onchip_sram_dual_port_controller_properties (
  input logic core_clk,
  input logic nrst,
  input sram_ctrl_pkg::pwr_state_e pwr_state,
  input sram_ctrl_pkg::sw_rd_req_s sw_rd,
  input sram_ctrl_pkg::sw_wr_req_s sw_wr,
  input logic sw_rd_ack,
  input logic sw_wr_ack,
  input logic sw_err,
  input logic disp_req,
  input logic [31:0] disp_addr,
  input logic disp_ack,
  input logic [5:0] pm_req,
  input logic [5:0] pm_to_run,
  input logic [5:0] pm_ack,
  input logic [5:0] arr_in_run
);
  import sram_ctrl_pkg::*;
  logic full; // switch may be served
  logic [2:0] didx; // display target array
  assign full = (pwr_state == PM_FULL_RUN);
  assign didx = {1'b0, disp_addr[19:18]} + (disp_addr[17] ? 3'h3 : 3'h0);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  rd_answer_a: assert property (full && sw_rd.valid && !sw_rd_ack |=> sw_rd_ack)
    else $error("read not answered next cycle");
  ack_pulse_a: assert property (sw_rd_ack |=> !sw_rd_ack)
    else $error("read ack longer than one cycle");
  idle_quiet_a: assert property (!full |=> !sw_rd_ack && !sw_wr_ack)
    else $error("switch answered outside full run");
  err_ack_a: assert property (sw_err |-> sw_rd_ack || sw_wr_ack)
    else $error("error without ack");
  boot_write_a: assert property (full && sw_wr.valid && !sw_wr_ack && !sw_rd.valid
    && sw_wr.addr[31:16] == 16'h5e00 |=> sw_wr_ack && sw_err)
    else $error("boot store write not refused");
  dual_bank_a: assert property (full && sw_rd.valid && sw_wr.valid && !sw_rd_ack
    && !sw_wr_ack && sw_rd.addr[31:20] == SRAM_TOP12 && sw_wr.addr[31:20] == SRAM_TOP12
    && sw_rd.addr[17] != sw_wr.addr[17] |=> sw_rd_ack && sw_wr_ack)
    else $error("read and write in two banks not both acked");
  disp_full_a: assert property (full && !disp_ack |=> !disp_ack)
    else $error("display answered in full run");
  disp_hold_a: assert property (disp_ack && disp_req |=> disp_ack)
    else $error("display ack dropped while request high");
  stall_run_a: assert property ($rose(disp_ack) && disp_addr[31:20] == SRAM_TOP12
    && disp_addr[19:18] != 2'h3 |-> $past(arr_in_run[didx]))
    else $error("display read finished before array ran");
  pm_hold_a: assert property (($past(pm_req & ~pm_ack)
    & (~pm_req | (pm_to_run ^ $past(pm_to_run)))) == 6'h00)
    else $error("power request changed before ack");
  pm_release_a: assert property (($past(pm_req & pm_ack) & pm_req) == 6'h00)
    else $error("power request not dropped after ack");
endmodule
bind onchip_sram_dual_port_controller onchip_sram_dual_port_controller_properties chk (
  .core_clk(core_clk), .nrst(nrst), .pwr_state(pwr_state), .sw_rd(sw_rd), .sw_wr(sw_wr),
  .sw_rd_ack(sw_rd_ack), .sw_wr_ack(sw_wr_ack), .sw_err(sw_err), .disp_req(disp_req),
  .disp_addr(disp_addr), .disp_ack(disp_ack), .pm_req(pm_req), .pm_to_run(pm_to_run),
  .pm_ack(pm_ack), .arr_in_run(arr_in_run));

// >>> bench/power_manager_model.sv
// Purpose: behavioural power manager for the per-array handshake
// Assumes: same clock as the block, requests held until acked
// Notes: lag sets answer delay, so prompt and slow replies are seen
`timescale 1ns/10ps
module power_manager_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] lag,
  input wire logic [5:0] pm_req,
  input wire logic [5:0] pm_to_run,
  output logic [5:0] pm_ack,
  output logic [5:0] arr_in_run
);
  logic [3:0] wait_q [6]; // per array delay count
  // grant after lag clocks, release ack once request drops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pm_ack <= 6'h00;
      arr_in_run <= 6'h3f; // arrays start powered
      for (int i = 0; i < 6; i++) wait_q[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (!pm_req[i]) begin
          pm_ack[i] <= 1'b0;
          wait_q[i] <= 4'h0;
        end else if (!pm_ack[i] && wait_q[i] == lag) begin
          pm_ack[i] <= 1'b1;
          arr_in_run[i] <= pm_to_run[i];
        end else if (!pm_ack[i]) begin
          wait_q[i] <= wait_q[i] + 4'h1;
        end
      end
    end
  end
endmodule

// >>> bench/onchip_sram_dual_port_controller_tb_top.sv
// Purpose: self-checking bench of the on-chip sram block
// Assumes: power manager model on the array handshake
// Notes: arrays shrunk to 64 words, boot store to 16
`timescale 1ns/10ps
module onchip_sram_dual_port_controller_tb_top;
  import sram_ctrl_pkg::*;
  logic core_clk = 1'b0; // 20 MHz
  logic nrst = 1'b0;
  pwr_state_e pwr_state = PM_FULL_RUN;
  sw_rd_req_s sw_rd = '0;
  sw_wr_req_s sw_wr = '0;
  logic sw_rd_ack, sw_wr_ack, sw_err, disp_ack;
  logic [31:0] sw_rd_data, disp_data;
  logic disp_req = 1'b0;
  logic [31:0] disp_addr = 32'h0;
  logic [5:0] cfg_auto_wake = 6'h01; // only array 0 auto wakes
  logic [IDLE_W-1:0] cfg_idle_timeout = 16'h0040; // 64 idle clocks
  logic [5:0] pm_req, pm_to_run, pm_ack, arr_in_run;
  logic [3:0] lag = 4'h0; // manager answer delay
  int miscompares = 0;
  int check_count = 0;
  always #25 core_clk = ~core_clk;
  onchip_sram_dual_port_controller #(.ARR_WORDS(64), .BOOT_WORDS(16)) uut (
    .core_clk(core_clk), .nrst(nrst), .pwr_state(pwr_state), .sw_rd(sw_rd), .sw_wr(sw_wr),
    .sw_rd_ack(sw_rd_ack), .sw_rd_data(sw_rd_data), .sw_wr_ack(sw_wr_ack), .sw_err(sw_err),
    .disp_req(disp_req), .disp_addr(disp_addr), .disp_ack(disp_ack), .disp_data(disp_data),
    .cfg_auto_wake(cfg_auto_wake), .cfg_idle_timeout(cfg_idle_timeout), .pm_req(pm_req),
    .pm_to_run(pm_to_run), .pm_ack(pm_ack), .arr_in_run(arr_in_run));
  power_manager_model mgr (.core_clk(core_clk), .nrst(nrst), .lag(lag), .pm_req(pm_req),
    .pm_to_run(pm_to_run), .pm_ack(pm_ack), .arr_in_run(arr_in_run));
  // start address of array i, lower arrays 0..2 then upper
  function automatic logic [31:0] base(input int i);
    return SRAM_BASE + 32'(i % 3) * 32'h0004_0000 + 32'(i / 3) * 32'h0002_0000;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // one switch access held until its ack edge
  task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] e, input logic ee);
    @(negedge core_clk);
    if (w) sw_wr = {1'b1, a, be, d};
    else sw_rd = {1'b1, a};
    repeat (9) begin
      @(posedge core_clk);
      #1;
      if ((w ? sw_wr_ack : sw_rd_ack) === 1'b1) break;
    end
    chk({30'h0, w ? sw_wr_ack : sw_rd_ack, sw_err}, {30'h0, 1'b1, ee});
    if (!w) chk(sw_rd_data, e);
    @(negedge core_clk);
    sw_wr.valid = 1'b0;
    sw_rd.valid = 1'b0;
  endtask
  // four-phase display read, n counts clocks to ack
  task automatic disp_rd(input logic [31:0] a, input logic [31:0] e, output int n);
    n = 0;
    @(negedge core_clk);
    disp_addr = a;
    disp_req = 1'b1;
    while (n < 60 && disp_ack !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(disp_data, e);
    @(negedge core_clk);
    disp_req = 1'b0;
    repeat (4) @(negedge core_clk);
    chk({31'h0, disp_ack}, 32'h0);
  endtask
  task automatic t_map;
    for (int i = 0; i < 6; i++) acc(1'b1, base(i) + 32'h10, 4'hf, base(i) ^ 32'h0f0f_0f0f,
      32'h0, 1'b0);
    for (int i = 0; i < 6; i++) acc(1'b0, base(i) + 32'h10, 4'h0, 32'h0,
      base(i) ^ 32'h0f0f_0f0f, 1'b0);
    $display("t_map done");
  endtask
  task automatic t_byte;
    acc(1'b1, base(1) + 32'h20, 4'hf, 32'h1122_3344, 32'h0, 1'b0);
    acc(1'b1, base(1) + 32'h20, 4'h2, 32'haabb_ccdd, 32'h0, 1'b0);
    acc(1'b0, base(1) + 32'h20, 4'h0, 32'h0, 32'h1122_cc44, 1'b0);
    $display("t_byte done");
  endtask
  task automatic t_rom;
    acc(1'b0, ROM_BASE + 32'h4, 4'h0, 32'h0, ROM_FILL, 1'b0);
    acc(1'b1, ROM_BASE + 32'h4, 4'hf, 32'h1234_5678, 32'h0, 1'b1);
    acc(1'b0, ROM_BASE + 32'h4, 4'h0, 32'h0, ROM_FILL, 1'b0);
    acc(1'b0, 32'h6000_0000, 4'h0, 32'h0, 32'h0, 1'b1);
    $display("t_rom done");
  endtask
  task automatic t_dual;
    @(negedge core_clk);
    sw_rd = {1'b1, base(0) + 32'h10};
    sw_wr = {1'b1, base(3) + 32'h20, 4'hf, 32'h5566_7788};
    @(posedge core_clk);
    #1;
    chk({30'h0, sw_rd_ack, sw_wr_ack}, 32'h3);
    chk(sw_rd_data, base(0) ^ 32'h0f0f_0f0f);
    @(negedge core_clk);
    sw_rd.valid = 1'b0;
    sw_wr.valid = 1'b0;
    acc(1'b0, base(3) + 32'h20, 4'h0, 32'h0, 32'h5566_7788, 1'b0);
    $display("t_dual done");
  endtask
  task automatic t_off;
    @(negedge core_clk);
    pwr_state = PM_DISPLAY;
    sw_rd = {1'b1, base(0)};
    repeat (5) begin
      @(posedge core_clk);
      chk({31'h0, sw_rd_ack}, 32'h0);
    end
    @(negedge core_clk);
    sw_rd.valid = 1'b0;
    pwr_state = PM_FULL_RUN;
    $display("t_off done");
  endtask
  task automatic t_disp;
    int n;
    @(negedge core_clk);
    pwr_state = PM_DISPLAY;
    repeat (100) @(negedge core_clk);
    chk({26'h0, arr_in_run}, 32'h0);
    lag = 4'h8;
    disp_rd(base(0) + 32'h10, base(0) ^ 32'h0f0f_0f0f, n);
    chk({31'h0, n > 10}, 32'h1);
    repeat (20) @(negedge core_clk);
    chk({26'h0, arr_in_run}, 32'h1);
    disp_rd(base(0) + 32'h10, base(0) ^ 32'h0f0f_0f0f, n);
    chk({31'h0, n < 8}, 32'h1);
    chk({30'h0, pm_req[0], pm_to_run[0]}, 32'h3);
    $display("t_disp done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    t_map();
    t_byte();
    t_rom();
    t_dual();
    t_off();
    t_disp();
    test_done();
  end
  // cut a hang short
  initial begin
    #2000000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
